/* rtl/vc0_arb_defs.svh */
/*
 Offsets, field positions, reset values and table load length of the VC0 arbitration registers.
 Assumes inclusion by bare name from the package and the register module.
*/
`ifndef VC0_ARB_DEFS_SVH
`define VC0_ARB_DEFS_SVH

`define PORT_VC_STATUS_OFF      12'h20E
`define VC0_CAP_OFF             12'h210
`define VC0_CTL_OFF             12'h214

`define COHERENT_BIT            0
`define SCHEME_SUPPORT_RST      8'h01
`define SCHEME_SUPPORT_LSB      0
`define ADV_SWITCH_BIT          14
`define SNOOP_REJECT_BIT        15
`define MAX_SLOTS_LSB           16
`define TABLE_OFFSET_LSB        24
`define TABLE_OFFSET_RST        8'h00

`define TC_MAP_RST              8'hFF
`define TC_MAP_LSB              0
`define LOAD_TABLE_BIT          16
`define SCHEME_SEL_LSB          17
`define SCHEME_SEL_RST          3'h0
`define CHANNEL_ID_LSB          24
`define CHANNEL_ENABLE_BIT      31

`define TABLE_LOAD_CYCLES       4'h4

`endif

/* rtl/vc0_arb_pkg.sv */
/*
 Types shared by the VC0 arbitration register files.
 Assumes the defs header is on the include path.
*/
`include "vc0_arb_defs.svh"
package vc0_arb_pkg;
  typedef logic [11:0] cfg_addr_t;
  typedef logic [31:0] cfg_word_t;
  typedef enum logic [1:0] {
    LOAD_IDLE = 2'b01,
    LOAD_BUSY = 2'b10
  } load_state_e;
endpackage : vc0_arb_pkg

/* rtl/table_load_if.sv */
/*
 Request and status lines between the register bank and the table loader.
 Assumes one clock shared by both ends.
*/
interface table_load_if;
  logic load_req;
  logic entry_write;
  logic pending;
  logic busy;
  modport regs   (output load_req, output entry_write, input pending, input busy);
  modport loader (input load_req, input entry_write, output pending, output busy);
endinterface : table_load_if

/* rtl/table_loader.sv */
/*
 Table coherency tracker: sets on an entry write, clears when a load finishes.
 Assumes requests arrive one cycle wide from the register bank.
*/
`include "vc0_arb_defs.svh"

module table_loader
  import vc0_arb_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_srst,
  // bank side
  table_load_if.loader lp
);
  load_state_e state_reg;
  logic [3:0]  count_reg;
  logic        pending_reg;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= LOAD_IDLE;
      count_reg <= 4'h0;
    end else begin
      case (state_reg)
        LOAD_IDLE: begin
          if (lp.load_req) begin
            state_reg <= LOAD_BUSY;
            count_reg <= `TABLE_LOAD_CYCLES;
          end
        end
        LOAD_BUSY: begin
          count_reg <= count_reg - 4'h1;
          if (count_reg == 4'h1) begin
            state_reg <= LOAD_IDLE;
          end
        end
        default: state_reg <= LOAD_IDLE;
      endcase
    end
  end

  // entry write beats a finishing load
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pending_reg <= 1'b0;
    end else if (lp.entry_write) begin
      pending_reg <= 1'b1;
    end else if (state_reg == LOAD_BUSY && count_reg == 4'h1) begin
      pending_reg <= 1'b0;
    end
  end

  assign lp.pending = pending_reg;
  assign lp.busy    = (state_reg == LOAD_BUSY);
endmodule : table_loader

/* rtl/vc0_port_arbitration_regs.sv */
/*
 Configuration registers of VC resource 0 for one switch port.
 Assumes a single-cycle config access port in the core clock domain.
*/
`include "vc0_arb_defs.svh"

// Summary of operation
// - status word bit 16 coherency flag, reset zero, other bits zero.
// - capability bits 7:0 list schemes, lock-writable, default 0x1.
// - one capability bit per scheme, several may be set.
// - advanced switching bit 14 always reads zero.
// - snoop reject bit 15 always reads zero.
// - max time slots bits 22:16 read zero.
// - table offset bits 31:24, 16-byte units, lock-writable, default zero.
// - traffic class map bits 7:0, bit 0 fixed, reset 0xFF.
// - writing one to bit 16 reloads arbitration from the table.
// - load bit always reads zero.
// - load only acts when selected scheme uses the table.
// - channel identifier bits 26:24 fixed at zero.
// - channel enable bit 31 fixed at one.
// - pending flag sets on entry write, clears when load completes.
module vc0_port_arbitration_regs
  import vc0_arb_pkg::*;
(
  // clock and reset
  input  wire logic      i_clk,
  input  wire logic      i_srst,
  // config access
  input  wire logic      i_cfg_wr,
  input  wire logic      i_cfg_rd,
  input  wire cfg_addr_t i_cfg_addr,
  input  wire cfg_word_t i_cfg_wdata,
  input  wire logic [3:0] i_cfg_be,
  output logic [31:0]    o_cfg_rdata,
  // lock for lock-writable fields
  input  wire logic      i_cfg_lock,
  // table and status from arbiter
  input  wire logic      i_table_entry_wr,
  input  wire logic      i_vc_table_coherent,
  // to the arbiter
  output logic [7:0]     o_traffic_class_map,
  output logic [2:0]     o_port_arb_scheme_select,
  output logic           o_round_robin,
  output logic           o_load_pulse,
  output logic           o_port_arb_table_pending,
  output logic           o_load_busy
);
  logic [7:0] scheme_support_reg;
  logic [7:0] table_offset_reg;
  logic [7:0] tc_map_reg;
  logic [2:0] scheme_sel_reg;
  logic       coherent_reg;
  logic       load_reg;
  logic       lock_reg;
  logic       sync_a_reg;
  logic       sync_b_reg;
  logic       entry_a_reg;
  logic       entry_b_reg;
  logic       entry_c_reg;
  logic       wr_cap;
  logic       wr_ctl;
  logic       load_req;

  table_load_if lp ();

  function automatic logic hit(input cfg_addr_t a, input cfg_addr_t off);
    hit = (a[11:2] == off[11:2]);
  endfunction : hit

  function automatic logic table_used(input logic [2:0] sel, input logic [7:0] cap);
    // only schemes above round robin consult the table
    table_used = cap[sel] && (sel != 3'h0);
  endfunction : table_used

  // reserved fields come from the zero base word; fixed fields are set explicitly
  function automatic cfg_word_t status_word(input logic flag);
    status_word = 32'h0000_0000;
    // status sits in the upper half of its word
    status_word[16 + `COHERENT_BIT] = flag;
  endfunction : status_word

  function automatic cfg_word_t cap_word(input logic [7:0] schemes, input logic [7:0] tbl_off);
    cap_word = 32'h0000_0000;
    cap_word[`SCHEME_SUPPORT_LSB +: 8] = schemes;
    cap_word[`ADV_SWITCH_BIT]          = 1'b0;
    cap_word[`SNOOP_REJECT_BIT]        = 1'b0;
    cap_word[`MAX_SLOTS_LSB +: 7]      = 7'h00;
    cap_word[`TABLE_OFFSET_LSB +: 8]   = tbl_off;
  endfunction : cap_word

  function automatic cfg_word_t ctl_word(input logic [7:0] tc_map, input logic [2:0] sel);
    ctl_word = 32'h0000_0000;
    ctl_word[`TC_MAP_LSB +: 8]     = tc_map;
    ctl_word[`LOAD_TABLE_BIT]      = 1'b0;
    ctl_word[`SCHEME_SEL_LSB +: 3] = sel;
    ctl_word[`CHANNEL_ID_LSB +: 3] = 3'h0;
    ctl_word[`CHANNEL_ENABLE_BIT]  = 1'b1;
  endfunction : ctl_word

  assign wr_cap = i_cfg_wr && hit(i_cfg_addr, `VC0_CAP_OFF);
  assign wr_ctl = i_cfg_wr && hit(i_cfg_addr, `VC0_CTL_OFF);

  // pin-level coherency flag passes two flops
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sync_a_reg <= 1'b0;
      sync_b_reg <= 1'b0;
    end else begin
      sync_a_reg <= i_vc_table_coherent;
      sync_b_reg <= sync_a_reg;
    end
  end

  // lock is a same-clock level; one flop keeps it off the write path
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      lock_reg <= 1'b0;
    end else begin
      lock_reg <= i_cfg_lock;
    end
  end

  // entry strobe: two sync flops, the third finds its rising edge
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      entry_a_reg <= 1'b0;
      entry_b_reg <= 1'b0;
      entry_c_reg <= 1'b0;
    end else begin
      entry_a_reg <= i_table_entry_wr;
      entry_b_reg <= entry_a_reg;
      entry_c_reg <= entry_b_reg;
    end
  end

  // flag registered once more before the read mux
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      coherent_reg <= 1'b0;
    end else begin
      coherent_reg <= sync_b_reg;
    end
  end

  // lock-writable capability fields
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      scheme_support_reg <= `SCHEME_SUPPORT_RST;
      table_offset_reg   <= `TABLE_OFFSET_RST;
    end else if (wr_cap && !lock_reg) begin
      if (i_cfg_be[0]) begin
        scheme_support_reg <= i_cfg_wdata[`SCHEME_SUPPORT_LSB +: 8];
      end
      if (i_cfg_be[3]) begin
        table_offset_reg <= i_cfg_wdata[`TABLE_OFFSET_LSB +: 8];
      end
    end
  end

  // class map and scheme select; the load bit is a strobe, not stored
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tc_map_reg     <= `TC_MAP_RST;
      scheme_sel_reg <= `SCHEME_SEL_RST;
    end else if (wr_ctl) begin
      if (i_cfg_be[0]) begin
        tc_map_reg <= {i_cfg_wdata[`TC_MAP_LSB + 7 : `TC_MAP_LSB + 1], 1'b1};
      end
      if (i_cfg_be[2]) begin
        scheme_sel_reg <= i_cfg_wdata[`SCHEME_SEL_LSB +: 3];
      end
    end
  end

  // load only on a written one under a table-using scheme; refused while a load runs
  assign load_req = wr_ctl && i_cfg_be[2] && i_cfg_wdata[`LOAD_TABLE_BIT]
                    && table_used(scheme_sel_reg, scheme_support_reg)
                    && !lp.busy && !load_reg;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      load_reg <= 1'b0;
    end else begin
      load_reg <= load_req;
    end
  end

  assign lp.load_req    = load_reg;
  assign lp.entry_write = entry_b_reg && !entry_c_reg;

  table_loader u_loader (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .lp     (lp)
  );

  // read mux; unmapped words read zero
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_cfg_rdata <= 32'h0000_0000;
    end else if (i_cfg_rd) begin
      if (hit(i_cfg_addr, `PORT_VC_STATUS_OFF)) begin
        o_cfg_rdata <= status_word(coherent_reg);
      end else if (hit(i_cfg_addr, `VC0_CAP_OFF)) begin
        o_cfg_rdata <= cap_word(scheme_support_reg, table_offset_reg);
      end else if (hit(i_cfg_addr, `VC0_CTL_OFF)) begin
        o_cfg_rdata <= ctl_word(tc_map_reg, scheme_sel_reg);
      end else begin
        o_cfg_rdata <= 32'h0000_0000;
      end
    end
  end

  assign o_traffic_class_map      = tc_map_reg;
  assign o_port_arb_scheme_select = scheme_sel_reg;
  assign o_round_robin            = (scheme_sel_reg == 3'h0);
  assign o_load_pulse             = load_reg;
  assign o_port_arb_table_pending = lp.pending;
  assign o_load_busy              = lp.busy;
endmodule : vc0_port_arbitration_regs

/* verif/vc0_port_arbitration_regs_chk.sv */
/* checker of the VC0 register bank ports.
 assumes it is bound onto the bank. */
module vc0_port_arbitration_regs_chk
  import vc0_arb_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic        i_cfg_rd,
  input wire cfg_addr_t   i_cfg_addr,
  input wire logic        i_table_entry_wr,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic [7:0]  o_traffic_class_map,
  input wire logic [2:0]  o_port_arb_scheme_select,
  input wire logic        o_round_robin,
  input wire logic        o_load_pulse,
  input wire logic        o_port_arb_table_pending,
  input wire logic        o_load_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  load_busy_a: assert property (o_load_pulse |=> o_load_busy [*4] ##1 !o_load_busy)
    else $error("busy window wrong after load");
  load_gate_a: assert property (o_load_pulse |-> !o_round_robin)
    else $error("load taken with round robin selected");
  rr_sel_a: assert property (o_round_robin == (o_port_arb_scheme_select == 3'h0))
    else $error("round robin flag disagrees with select");
  tc_fixed_a: assert property (o_traffic_class_map[0])
    else $error("class 0 unmapped");
  pend_set_a: assert property ($rose(i_table_entry_wr) |-> ##[1:3] o_port_arb_table_pending)
    else $error("pending not set after entry write");
  ctl_read_a: assert property (i_cfg_rd && i_cfg_addr[11:2] == 10'h085 |=>
    o_cfg_rdata[31:20] == 12'h800 && !o_cfg_rdata[16] && o_cfg_rdata[15:8] == 8'h00 &&
    o_cfg_rdata[7:0] == o_traffic_class_map)
    else $error("control word read wrong");
  cap_read_a: assert property (i_cfg_rd && i_cfg_addr[11:2] == 10'h084 |=>
    o_cfg_rdata[23:8] == 16'h0000)
    else $error("capability fixed bits wrong");
  stat_read_a: assert property (i_cfg_rd && i_cfg_addr[11:2] == 10'h083 |=>
    o_cfg_rdata[31:17] == 15'h0000)
    else $error("status reserved bits set");
endmodule : vc0_port_arbitration_regs_chk

bind vc0_port_arbitration_regs vc0_port_arbitration_regs_chk chk_u (.i_clk, .i_srst,
  .i_cfg_rd, .i_cfg_addr, .i_table_entry_wr, .o_cfg_rdata, .o_traffic_class_map,
  .o_port_arb_scheme_select, .o_round_robin, .o_load_pulse, .o_port_arb_table_pending,
  .o_load_busy);

/* verif/test_vc0_port_arbitration_regs.sv */
/* self-checking bench of the VC0 register bank.
 assumes the checker file is compiled with it. */
module test_vc0_port_arbitration_regs
  import vc0_arb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 1'b0, i_srst = 1'b1, i_cfg_wr = 1'b0, i_cfg_rd = 1'b0;
  logic        i_cfg_lock = 1'b0, i_table_entry_wr = 1'b0, i_vc_table_coherent = 1'b0;
  cfg_addr_t   i_cfg_addr = 12'h000;
  cfg_word_t   i_cfg_wdata = 32'h0000_0000;
  logic [3:0]  i_cfg_be = 4'h0;
  logic [31:0] o_cfg_rdata, rd;
  logic [7:0]  o_traffic_class_map;
  logic [2:0]  o_port_arb_scheme_select;
  logic        o_round_robin, o_load_pulse, o_port_arb_table_pending, o_load_busy;
  int          n_errors = 0;
  int          n_compared = 0;
  always #50 i_clk = ~i_clk;
  vc0_port_arbitration_regs dut_u (.i_clk, .i_srst, .i_cfg_wr, .i_cfg_rd, .i_cfg_addr,
    .i_cfg_wdata, .i_cfg_be, .o_cfg_rdata, .i_cfg_lock, .i_table_entry_wr,
    .i_vc_table_coherent, .o_traffic_class_map, .o_port_arb_scheme_select, .o_round_robin,
    .o_load_pulse, .o_port_arb_table_pending, .o_load_busy);
  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  task automatic cfg_write(input cfg_addr_t a, input cfg_word_t d, input logic [3:0] be);
    @(posedge i_clk);
    i_cfg_wr <= 1'b1;
    i_cfg_addr <= a;
    i_cfg_wdata <= d;
    i_cfg_be <= be;
    @(posedge i_clk);
    i_cfg_wr <= 1'b0;
    #1;
  endtask : cfg_write
  task automatic cfg_read(input cfg_addr_t a);
    @(posedge i_clk);
    i_cfg_rd <= 1'b1;
    i_cfg_addr <= a;
    @(posedge i_clk);
    i_cfg_rd <= 1'b0;
    #1 rd = o_cfg_rdata;
  endtask : cfg_read
  // bounded wait on pulse (0), busy (1) or pending (2)
  task automatic wait_for(input int k, input logic v, input int lim);
    int i;
    #1;
    for (i = 0; i < lim && (k == 0 ? o_load_pulse : k == 1 ? o_load_busy
         : o_port_arb_table_pending) !== v; i++) begin
      @(posedge i_clk);
      #1;
    end
    if (i == lim) begin
      n_errors++;
      $display("unexpected wait %0d: expected %0d, seen timeout", k, v);
      print_verdict();
    end
  endtask : wait_for
  task automatic t_reset;
    cfg_read(12'h214);
    check("ctl reset", 32'h8000_00FF, rd);
    cfg_read(12'h210);
    check("cap reset", 32'h0000_0001, rd);
    cfg_read(12'h20C);
    check("status reset", 32'h0000_0000, {16'h0000, rd[31:16]});
    check("rr reset", 32'h0000_0001, {31'h0, o_round_robin});
    $display("done reset");
  endtask : t_reset
  task automatic t_ctl;
    cfg_write(12'h214, 32'h7FF0_FF00, 4'hF);
    cfg_read(12'h214);
    check("ctl fixed", 32'h8000_0001, rd);
    cfg_write(12'h214, 32'h0000_00AA, 4'h1);
    check("tc map", 32'h0000_00AB, {24'h0, o_traffic_class_map});
    $display("done ctl");
  endtask : t_ctl
  task automatic t_cap;
    cfg_write(12'h210, 32'hFFFF_FFFF, 4'hF);
    cfg_read(12'h210);
    check("cap open", 32'hFF00_00FF, rd);
    @(posedge i_clk) i_cfg_lock <= 1'b1;
    cfg_write(12'h210, 32'h0000_0000, 4'hF);
    cfg_read(12'h210);
    check("cap locked", 32'hFF00_00FF, rd);
    @(posedge i_clk) i_cfg_lock <= 1'b0;
    cfg_write(12'h210, 32'h1200_0003, 4'hF);
    cfg_read(12'h210);
    check("cap two", 32'h1200_0003, rd);
    $display("done cap");
  endtask : t_cap
  task automatic t_load;
    cfg_write(12'h214, 32'h0002_0000, 4'h4);
    cfg_read(12'h214);
    check("select one", 32'h8002_00AB, rd);
    check("select out", 32'h0000_0001, {29'h0, o_port_arb_scheme_select});
    @(posedge i_clk) i_table_entry_wr <= 1'b1;
    @(posedge i_clk) i_table_entry_wr <= 1'b0;
    wait_for(2, 1'b1, 5);
    cfg_write(12'h214, 32'h0003_0000, 4'h4);
    wait_for(0, 1'b1, 2);
    wait_for(1, 1'b1, 2);
    wait_for(1, 1'b0, 6);
    check("pending cleared", 32'h0, {31'h0, o_port_arb_table_pending});
    cfg_read(12'h214);
    check("load reads zero", 32'h8002_00AB, rd);
    @(posedge i_clk) i_vc_table_coherent <= 1'b1;
    repeat (5) @(posedge i_clk);
    cfg_read(12'h20C);
    check("coherent flag", 32'h0000_0001, {16'h0000, rd[31:16]});
    $display("done load");
  endtask : t_load
  task automatic t_noload;
    logic seen;
    seen = 1'b0;
    cfg_write(12'h214, 32'h0004_0000, 4'h4);
    seen = seen | o_load_pulse;
    cfg_write(12'h214, 32'h0005_0000, 4'h4);
    seen = seen | o_load_pulse;
    cfg_write(12'h214, 32'h0000_0000, 4'h4);
    cfg_write(12'h214, 32'h0001_0000, 4'h4);
    seen = seen | o_load_pulse;
    repeat (8) begin
      #1 seen = seen | o_load_pulse;
      @(posedge i_clk);
    end
    check("no load", 32'h0, {31'h0, seen});
    check("rr select", 32'h0000_0001, {31'h0, o_round_robin});
    cfg_read(12'h300);
    check("unmapped", 32'h0000_0000, rd);
    $display("done noload");
  endtask : t_noload
  initial begin
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    t_reset();
    t_ctl();
    t_cap();
    t_load();
    t_noload();
    print_verdict();
  end
endmodule : test_vc0_port_arbitration_regs
